/* design/pfc_fault_standby_supervisor.sv */
// Purpose : Fault, standby and pin supervision for a PFC gate driver.
// Assumes : All comparator inputs are synchronous to sys_clk.
// Notes   : Registers reached over AHB-Lite; zero wait states.
`timescale 1ns/1ps
module pfc_fault_standby_supervisor
  import supervisor_pkg::*;
#(
  parameter int GND_CYC   = GND_FAULT_CYC,
  parameter int WDOG_CYC  = WATCHDOG_CYC,
  parameter int OVS_CYC   = OVERSTRESS_CYC,
  parameter int OTPB_CYC  = OTP_BLANK_CYC,
  parameter int STBB_CYC  = STBY_BLANK_CYC
)
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Comparator and system inputs.
  input  wire logic        gnd_diode_current,
  input  wire logic        sense_at_rail,
  input  wire logic        zero_detect_edge,
  input  wire logic        sense_above_arm,
  input  wire logic        fault_above_upper,
  input  wire logic        fault_below_lower,
  input  wire logic        fault_above_release,
  input  wire logic        vcc_on_level,
  input  wire logic        vcc_above_reset,
  input  wire logic        vcc_uvlo,
  input  wire logic        brownout,
  input  wire logic        power_saving_mode,
  input  wire logic        standby_input_pin,
  input  wire logic        bulk_below_restart,
  input  wire logic        bulk_regulated,
  input  wire logic        restart_pin_low,
  input  wire logic        power_good_output,
  input  wire logic        gate_request,
  // Outputs to the pins and the rest of the controller.
  output logic             gate_drive,
  output logic             strong_sense_pullup,
  output logic             otp_bias_enable,
  output logic             shutdown_signal
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  op_state_t   state_r;
  op_state_t   state_nxt;
  logic [1:0]  ctrl_r;
  logic [7:0]  addr_r;
  logic        wr_pend_r;
  logic [31:0] rdata_r;
  logic        gate_r;
  logic        pullup_r;
  logic        arm_ok_r;
  logic        overstress_r;
  logic        latch_r;
  logic        otp_hold_r;
  logic        release_seen_r;
  logic        started_r;
  logic        burst_r;
  logic        gnd_exp;
  logic        wdog_exp;
  logic        ovs_exp;
  logic        ovp_exp;
  logic        otp_exp;
  logic        otpb_exp;
  logic        stbb_exp;
  wire         latching    = ctrl_r[CTRL_LATCH_BIT];
  wire         drv_en      = ctrl_r[CTRL_DRVEN_BIT];
  wire         addr_phase  = hsel && htrans[1] && hready;
  wire         running     = (state_r == ST_RUN) || (state_r == ST_STANDBY);
  wire [31:0]  status_word = {22'h0, burst_r, started_r, otp_hold_r, overstress_r,
                              arm_ok_r, pullup_r, latch_r, gate_r, state_r};

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------

  // Every transfer completes in one data-phase cycle with OKAY.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_r;

  // Read data is fetched in the address phase so it stands in the data phase.
  wire [31:0] rd_sel = (haddr[7:0] == CTRL_OFF)   ? {30'h0, ctrl_r} :
                       (haddr[7:0] == STATUS_OFF) ? status_word : 32'h0;

  // Address phase capture and write completion.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_r    <= 8'h00;
      wr_pend_r <= 1'b0;
      rdata_r   <= 32'h0;
      ctrl_r    <= CTRL_RESET;
    end else begin
      if (hready) begin
        wr_pend_r <= addr_phase && hwrite;
        addr_r    <= haddr[7:0];
      end
      if (addr_phase && !hwrite) begin
        rdata_r <= rd_sel;
      end
      if (wr_pend_r && addr_r == CTRL_OFF) begin
        ctrl_r <= hwdata[1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------

  // Lost ground: diode current held for the ground fault time.
  qual_timer u_gnd (.sys_clk(sys_clk), .rst_n(rst_n), .cond(gnd_diode_current),
    .limit(CNT_W'(GND_CYC)), .expired(gnd_exp));

  // Watchdog: no zero-current transition while running.
  qual_timer u_wdog (.sys_clk(sys_clk), .rst_n(rst_n), .cond(running && !zero_detect_edge),
    .limit(CNT_W'(WDOG_CYC)), .expired(wdog_exp));

  // Overstress off period runs while the overstress latch is set.
  qual_timer u_ovs (.sys_clk(sys_clk), .rst_n(rst_n), .cond(overstress_r),
    .limit(CNT_W'(OVS_CYC)), .expired(ovs_exp));

  // Upper fault blanking, armed only above the supply reset level.
  qual_timer u_ovp (.sys_clk(sys_clk), .rst_n(rst_n),
    .cond(fault_above_upper && vcc_above_reset),
    .limit(FAULT_BLANK_CYC), .expired(ovp_exp));

  // Power-up blanking of the temperature input, started with the bias.
  qual_timer u_otpb (.sys_clk(sys_clk), .rst_n(rst_n), .cond(started_r),
    .limit(CNT_W'(OTPB_CYC)), .expired(otpb_exp));

  // Lower fault blanking, after the power-up blanking ends or while the auto-recovery hold is set.
  qual_timer u_otp (.sys_clk(sys_clk), .rst_n(rst_n),
    .cond(fault_below_lower && (otpb_exp || otp_hold_r)),
    .limit(FAULT_BLANK_CYC), .expired(otp_exp));

  // Standby blanking after power-good rises.
  qual_timer u_stbb (.sys_clk(sys_clk), .rst_n(rst_n), .cond(power_good_output),
    .limit(CNT_W'(STBB_CYC)), .expired(stbb_exp));

  // ----------------------------------------------------------------
  // Fault qualification
  // ----------------------------------------------------------------

  // Conditions that take the latch, and events that release it.
  wire latch_set   = ovp_exp || gnd_exp || (otp_exp && latching);
  wire latch_clr   = brownout || !vcc_above_reset || power_saving_mode;
  // Level disables that stop the controller while they last.
  wire open_pin    = sense_at_rail || restart_pin_low;
  wire disable_lvl = open_pin || otp_hold_r || brownout || vcc_uvlo;
  // Overstress: arming level seen while the switch conducts.
  wire ovs_set     = gate_r && sense_above_arm;
  // Standby entry needs power-good, its blanking, and a high standby pin.
  wire stby_enter  = standby_input_pin && power_good_output && stbb_exp;

  // Fault latch: a new set in the clearing cycle still wins.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_r <= 1'b0;
    end else begin
      latch_r <= latch_set || (latch_r && !latch_clr);
    end
  end

  // Auto-recovery hold: cleared by release level then turn-on level.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      otp_hold_r     <= 1'b0;
      release_seen_r <= 1'b0;
    end else begin
      if (otp_exp && !latching) begin
        otp_hold_r     <= 1'b1;
        release_seen_r <= 1'b0;
      end else if (otp_hold_r) begin
        release_seen_r <= release_seen_r || fault_above_release;
        if (release_seen_r && vcc_on_level) begin
          otp_hold_r <= 1'b0;
        end
      end
    end
  end

  // Bias source: on from turn-on level until the supply falls to reset.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      started_r <= 1'b0;
    end else if (!vcc_above_reset) begin
      started_r <= 1'b0;
    end else if (vcc_on_level) begin
      started_r <= 1'b1;
    end
  end

  // Held by the auto-recovery fault whatever the supply, dropped when it clears.
  assign otp_bias_enable = otp_hold_r ? fault_below_lower : started_r;

  // ----------------------------------------------------------------
  // Sense pin supervision
  // ----------------------------------------------------------------

  // Pull-up and arming flags; an expired watchdog disarms until the pin rises.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pullup_r <= 1'b0;
      arm_ok_r <= 1'b0;
    end else begin
      if (wdog_exp) begin
        pullup_r <= 1'b1;
      end else if (zero_detect_edge) begin
        pullup_r <= 1'b0;
      end
      if (sense_above_arm) begin
        arm_ok_r <= 1'b1;
      end else if (wdog_exp) begin
        arm_ok_r <= 1'b0;
      end
    end
  end

  assign strong_sense_pullup = pullup_r;

  // Overstress latch; end of the off period clears it unless set again.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      overstress_r <= 1'b0;
    end else begin
      overstress_r <= ovs_set || (overstress_r && !ovs_exp);
    end
  end

  // ----------------------------------------------------------------
  // Operating state
  // ----------------------------------------------------------------

  // Latch wins over every other path; level disables fall back to off.
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_OFF: begin
        if (latch_set) begin
          state_nxt = ST_LATCHED;
        end else if (started_r && vcc_on_level && !disable_lvl) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (latch_set) begin
          state_nxt = ST_LATCHED;
        end else if (disable_lvl) begin
          state_nxt = ST_OFF;
        end else if (stby_enter) begin
          state_nxt = ST_STANDBY;
        end
      end
      ST_STANDBY: begin
        if (latch_set) begin
          state_nxt = ST_LATCHED;
        end else if (disable_lvl) begin
          state_nxt = ST_OFF;
        end else if (!standby_input_pin || !power_good_output) begin
          state_nxt = ST_RUN;
        end
      end
      ST_LATCHED: begin
        if (latch_clr && !latch_set) begin
          state_nxt = ST_OFF;
        end
      end
    endcase
  end

  // State register and standby burst flag.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_OFF;
      burst_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (state_r != ST_STANDBY || bulk_regulated) begin
        burst_r <= 1'b0;
      end else if (bulk_below_restart) begin
        burst_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Driver inhibit
  // ----------------------------------------------------------------

  // All disable, latch, protection and standby terms meet in one inhibit.
  assign shutdown_signal = !running || latch_r;
  wire inhibit = shutdown_signal || !arm_ok_r || overstress_r || !drv_en ||
                 ((state_r == ST_STANDBY) && !burst_r);

  // Gate register; sinking from the cycle after inhibit holds.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gate_r <= 1'b0;
    end else begin
      gate_r <= gate_request && !inhibit;
    end
  end

  assign gate_drive = gate_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_latch_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (brownout && !latch_set) |=> !latch_r) else $error("brownout did not clear latch");
  a_psm_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (power_saving_mode && !latch_set && state_r == ST_LATCHED) |=> state_r == ST_OFF)
    else $error("power saving did not leave latch");
  a_gate_sinking: assert property (@(posedge sys_clk) disable iff (!rst_n)
    shutdown_signal |=> !gate_drive) else $error("gate driven while shut down");
  a_stby_refuse: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!power_good_output && state_r == ST_RUN) |=> state_r != ST_STANDBY)
    else $error("standby entered without power good");
  a_pullup_wdog: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wdog_exp |=> pullup_r && ($past(sense_above_arm) || !arm_ok_r)) else $error("pull-up missed");
  a_ovs_period: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ovs_set |=> overstress_r ##1 !gate_drive) else $error("overstress not enforced");
  a_arm_block: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !arm_ok_r |=> !gate_drive) else $error("drive before arming level");
  a_ovp_reset: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !vcc_above_reset |=> !ovp_exp) else $error("upper fault below reset level");
  a_bias_powerup: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !vcc_above_reset && !otp_exp && !otp_hold_r |=> !otp_bias_enable) else $error("bias in reset");
  a_stby_blank: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(power_good_output) |-> ##1 (state_r != ST_STANDBY)[*3])
    else $error("standby taken inside blanking");

endmodule

/* design/supervisor_pkg.sv */
// Purpose : Shared constants for the power-factor supervisor.
// Assumes : A 100 MHz system clock.
// Notes   : Times are kept in their own units; cycle counts derive from them.
package supervisor_pkg;

  // ----------------------------------------------------------------
  // Clock and timer sizing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int CNT_W   = 20;

  // Times in microseconds.
  localparam int GND_FAULT_US   = 200;
  localparam int WATCHDOG_US    = 200;
  localparam int OVERSTRESS_US  = 1000;
  localparam int FAULT_BLANK_US = 30;
  localparam int OTP_BLANK_US   = 5000;
  localparam int STBY_BLANK_US  = 1000;

  // Cycle counts derived from the times.
  localparam int GND_FAULT_CYC  = GND_FAULT_US * CLK_MHZ;
  localparam int WATCHDOG_CYC   = WATCHDOG_US * CLK_MHZ;
  localparam int OVERSTRESS_CYC = OVERSTRESS_US * CLK_MHZ;
  localparam int OTP_BLANK_CYC  = OTP_BLANK_US * CLK_MHZ;
  localparam int STBY_BLANK_CYC = STBY_BLANK_US * CLK_MHZ;
  localparam logic [CNT_W-1:0] FAULT_BLANK_CYC = CNT_W'(FAULT_BLANK_US * CLK_MHZ);

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFF   = 8'h00;
  localparam logic [7:0] STATUS_OFF = 8'h04;

  // Control fields and reset values.
  localparam int CTRL_LATCH_BIT = 0;
  localparam int CTRL_DRVEN_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h3;

  // Operating states, Gray coded along off, run, standby, latched.
  typedef enum logic [1:0] {
    ST_OFF     = 2'h0,
    ST_RUN     = 2'h1,
    ST_STANDBY = 2'h3,
    ST_LATCHED = 2'h2
  } op_state_t;

endpackage

/* design/qual_timer.sv */
// Purpose : Blanking and watchdog counter that runs while its condition holds.
// Assumes : The condition is synchronous to sys_clk.
// Notes   : Expired rises after limit cycles of the condition held high.
`timescale 1ns/1ps
module qual_timer
  import supervisor_pkg::*;
(
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             cond,
  input  wire logic [CNT_W-1:0] limit,
  output logic                  expired
);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;

  // Counter restarts at once when the condition drops, and saturates at the limit.
  assign cnt_nxt = !cond ? '0 : (cnt_r == limit) ? cnt_r : cnt_r + 1'b1;
  assign expired = cond && (cnt_r == limit);

  // Count register.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // A dropped condition clears the expiry on the next cycle.
  a_timer_restart: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !cond |=> !expired) else $error("timer kept expiry after condition dropped");

endmodule

/* tb/boost_stage_model.sv */
// Purpose : Behavioural boost stage and sensing network seen at the supervisor pins.
// Assumes : Switch conduction follows gate_drive; the bench picks the failure mode.
// Notes   : A grounded sense pin never arms; a shorted diode arms during conduction.
`timescale 1ns/1ps
module boost_stage_model (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic gate_drive,
  input  wire logic pin_grounded,
  input  wire logic diode_short,
  output logic      sense_above_arm,
  output logic      zero_detect_edge
);
  logic gate_q_r;

  // The pin passes the arming level while the switch is off, or always with a short, unless the pin is grounded.
  assign sense_above_arm = !pin_grounded && (diode_short || !gate_drive);

  // A zero-current transition follows each switch turn-off, unless the pin is grounded.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gate_q_r         <= 1'b0;
      zero_detect_edge <= 1'b0;
    end else begin
      gate_q_r         <= gate_drive;
      zero_detect_edge <= !pin_grounded && gate_q_r && !gate_drive;
    end
  end
endmodule

/* tb/tb.sv */
// Purpose : Self-checking bench for the supervisor, random gate traffic with corner cases.
// Assumes : Short timer parameters; the fault blanking stays at its package value.
// Notes   : Gate checks compare each cycle against the request of the cycle before.
`timescale 1ns/1ps
module tb;
  import supervisor_pkg::*;
  localparam int WD = 300, OV = 100, SB = 60, GC = 40, LIMIT = 40000;
  localparam int FB = int'(FAULT_BLANK_CYC);
  logic sys_clk = 1'b0, rst_n = 1'b0;
  logic hsel, hwrite, hreadyout, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, q, seed;
  wire logic hready = hreadyout;
  logic gnd_diode_current, sense_at_rail, zero_detect_edge, sense_above_arm;
  logic fault_above_upper, fault_below_lower, fault_above_release, vcc_on_level;
  logic vcc_above_reset, vcc_uvlo, brownout, power_saving_mode, standby_input_pin;
  logic bulk_below_restart, bulk_regulated, restart_pin_low, power_good_output;
  logic gate_request, gate_drive, strong_sense_pullup, otp_bias_enable, shutdown_signal;
  logic pin_grounded, diode_short;
  int mismatches = 0, compares = 0, cycles = 0, cnt;

  always #5 sys_clk = ~sys_clk;

  pfc_fault_standby_supervisor #(.GND_CYC(GC), .WDOG_CYC(WD), .OVS_CYC(OV), .OTPB_CYC(50),
    .STBB_CYC(SB)) DUT (.sys_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .gnd_diode_current, .sense_at_rail,
    .zero_detect_edge, .sense_above_arm, .fault_above_upper, .fault_below_lower,
    .fault_above_release, .vcc_on_level, .vcc_above_reset, .vcc_uvlo, .brownout,
    .power_saving_mode, .standby_input_pin, .bulk_below_restart, .bulk_regulated,
    .restart_pin_low, .power_good_output, .gate_request, .gate_drive, .strong_sense_pullup,
    .otp_bias_enable, .shutdown_signal);

  boost_stage_model far_side (.sys_clk, .rst_n, .gate_drive, .pin_grounded, .diode_short,
    .sense_above_arm, .zero_detect_edge);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk1(input logic got, input logic exp, input string what);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // One AHB-Lite single word transfer; read data is taken at the data phase edge.
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w; hsize <= 3'h2;
    do @(posedge sys_clk); while (hready !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge sys_clk); while (hready !== 1'b1);
    q = hrdata;
  endtask

  task automatic hold(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic note(input string s);
    $display("test done: %s", s);
  endtask

  // Random gate requests; gate_drive must follow one cycle later or stay low.
  task automatic follow(input int n, input int skip, input logic en);
    logic prev;
    prev = gate_request;
    for (int i = 0; i < n + skip; i++) begin
      @(posedge sys_clk);
      seed = lfsr(seed);
      gate_request <= seed[0];
      #1;
      if (i >= skip) chk1(gate_drive, en & prev, "gate drive");
      prev = seed[0];
    end
  endtask

  // Drives one fault input: 0 upper fault, 1 ground diode current, else lower fault.
  task automatic set_fault(input int which, input logic v);
    case (which)
      0: fault_above_upper <= v;
      1: gnd_diode_current <= v;
      default: fault_below_lower <= v;
    endcase
  endtask

  // Holds one fault input long enough to pass blanking, then checks the latch.
  task automatic trip(input int which, input int n);
    set_fault(which, 1'b1);
    hold(n);
    set_fault(which, 1'b0);
    hold(20);
    chk1(shutdown_signal, 1'b1, "latched off");
  endtask

  task automatic released(input string s);
    hold(10);
    chk1(shutdown_signal, 1'b0, s);
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      mismatches++;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {hsel, hwrite, gate_request, gnd_diode_current, sense_at_rail, fault_above_upper,
     fault_below_lower, fault_above_release, vcc_on_level, vcc_above_reset, vcc_uvlo,
     brownout, power_saving_mode, standby_input_pin, bulk_below_restart, bulk_regulated,
     restart_pin_low, power_good_output, pin_grounded, diode_short} = '0;
    htrans = 2'h0; hsize = 3'h2; haddr = '0; hwdata = '0; seed = 32'h3e181afe;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1;
    chk1(shutdown_signal, 1'b1, "off at reset");
    chk1(otp_bias_enable, 1'b0, "bias at reset");
    bus(1'b0, {24'h0, CTRL_OFF}, 32'h0);
    chk32(q, 32'h3, "ctrl reset value");
    chk1(hresp, 1'b0, "okay response");
    bus(1'b0, {24'h0, STATUS_OFF}, 32'h0);
    chk32({30'h0, q[1:0]}, {30'h0, ST_OFF}, "state off");
    bus(1'b1, {24'h0, STATUS_OFF}, 32'hffffffff);
    bus(1'b0, 32'h10, 32'h0);
    chk32(q, 32'h0, "unmapped read");
    note("registers");
    vcc_above_reset <= 1'b1; vcc_on_level <= 1'b1; fault_above_release <= 1'b1;
    hold(5);
    chk1(shutdown_signal, 1'b0, "running");
    chk1(otp_bias_enable, 1'b1, "bias on");
    follow(200, 4, 1'b1);
    chk1(strong_sense_pullup, 1'b0, "pullup idle");
    bus(1'b1, {24'h0, CTRL_OFF}, 32'h1);
    follow(30, 3, 1'b0);
    bus(1'b1, {24'h0, CTRL_OFF}, 32'h3);
    follow(30, 4, 1'b1);
    note("run");
    standby_input_pin <= 1'b1;
    follow(80, 2, 1'b1);
    power_good_output <= 1'b1;
    follow(SB - 10, 2, 1'b1);
    follow(40, 15, 1'b0);
    bulk_below_restart <= 1'b1;
    follow(40, 4, 1'b1);
    bulk_below_restart <= 1'b0; bulk_regulated <= 1'b1;
    follow(40, 4, 1'b0);
    standby_input_pin <= 1'b0; bulk_regulated <= 1'b0;
    follow(40, 6, 1'b1);
    note("standby");
    diode_short <= 1'b1;
    cnt = 0;
    repeat (4 * OV) begin
      @(posedge sys_clk);
      seed = lfsr(seed);
      gate_request <= seed[0];
      #1;
      cnt += int'(gate_drive);
    end
    chk1(cnt <= 12, 1'b1, "low duty with short");
    diode_short <= 1'b0;
    follow(60, OV + 6, 1'b1);
    pin_grounded <= 1'b1;
    follow(20, WD + 10, 1'b0);
    chk1(strong_sense_pullup, 1'b1, "strong pullup");
    pin_grounded <= 1'b0;
    follow(40, 8, 1'b1);
    chk1(strong_sense_pullup, 1'b0, "pullup released");
    note("sense pin");
    fault_above_upper <= 1'b1;
    hold(FB - 20 - int'(seed[5:0] % 32'd40));
    fault_above_upper <= 1'b0;
    hold(5);
    chk1(shutdown_signal, 1'b0, "short fault ignored");
    trip(0, FB + 5);
    follow(20, 0, 1'b0);
    brownout <= 1'b1; hold(1); brownout <= 1'b0;
    released("brownout clears");
    trip(0, FB + 5);
    power_saving_mode <= 1'b1; hold(1); power_saving_mode <= 1'b0;
    released("saving mode clears");
    trip(1, GC + 5);
    vcc_above_reset <= 1'b0; hold(2); vcc_above_reset <= 1'b1;
    released("supply reset clears");
    note("latch");
    sense_at_rail <= 1'b1; hold(4);
    chk1(shutdown_signal, 1'b1, "open sense pin");
    sense_at_rail <= 1'b0; hold(6);
    chk1(shutdown_signal, 1'b0, "sense pin closed");
    restart_pin_low <= 1'b1; hold(4);
    chk1(shutdown_signal, 1'b1, "open restart pin");
    restart_pin_low <= 1'b0; hold(6);
    chk1(shutdown_signal, 1'b0, "restart pin closed");
    vcc_uvlo <= 1'b1; hold(4);
    chk1(shutdown_signal, 1'b1, "undervoltage lockout");
    vcc_uvlo <= 1'b0; hold(6);
    chk1(shutdown_signal, 1'b0, "lockout released");
    note("open pins");
    fault_above_release <= 1'b0;
    // The lower fault only counts once the power-up blanking after the supply cycle ends.
    trip(2, FB + 60);
    fault_above_release <= 1'b1;
    hold(10);
    chk1(shutdown_signal, 1'b1, "latching variant");
    brownout <= 1'b1; hold(1); brownout <= 1'b0;
    released("latch cleared");
    bus(1'b1, {24'h0, CTRL_OFF}, 32'h2);
    fault_above_release <= 1'b0; fault_below_lower <= 1'b1;
    hold(FB + 5);
    chk1(shutdown_signal, 1'b1, "lower fault off");
    chk1(otp_bias_enable, 1'b1, "bias held");
    fault_below_lower <= 1'b0;
    hold(5);
    chk1(otp_bias_enable, 1'b0, "bias dropped");
    chk1(shutdown_signal, 1'b1, "await release");
    fault_above_release <= 1'b1;
    hold(10);
    chk1(shutdown_signal, 1'b0, "auto recovery");
    note("fault pin");
    close_out();
  end
endmodule
